// ===== rtl/sfc_engine.sv
// Serial flash command engine: link decoder, buffers, array and self-timed jobs
// How it works
// RULE1: Host waits gap after each burst page end
// RULE2: Burst read wraps array end to page zero
// RULE3: Select high ends read, output floats
// RULE4: Burst read uses array, buffers untouched
// RULE5: Page read: opcode, 24 address, 32 dummy
// RULE6: Address: reserved, page, byte offset
// RULE7: Page read wraps within same page
// RULE8: Buffer read: opcode, 15 dummy, address, 8 dummy
// RULE9: Buffer read wraps to first byte
// RULE10: Status opcode then eight bits, MSB first
// RULE11: Status repeats with fresh values each pass
// RULE12: Bit seven high when idle, low busy
// RULE13: Stopped clock keeps showing live ready bit
// RULE14: Array jobs hold busy until finished
// RULE15: Bit six holds latest compare mismatch
// RULE16: Bits five to three fixed density code
// RULE17: Buffer write: opcode, 15 dummy, start address
// RULE18: Buffer write pointer wraps to first byte
// RULE19: Erase then program page from buffer
// RULE20: Program page from buffer without erase
// RULE21: Page erase sets page to ones
// RULE22: Block erase sets eight pages to ones
// RULE23: Sample input on rise, drive on fall
// RULE24: All fields move most significant bit first
// RULE25: Host starts no array job while busy
// RULE26: Select fall starts; high ignores, floats output
// RULE27: Unknown opcode ignored until select cycles
`timescale 1ns/1ps
module sfc_engine (
  input logic REF_CLK,
  input logic RST,
  input logic CS_N,
  input logic SCK,
  input logic SI,
  output logic SO,
  output logic SO_OE_N,
  output logic READY
);
  typedef struct packed {
    sfc_pkg::sfc_ser_e ser;
    logic cs_q;
    logic sck_q;
    logic [7:0] opc;
    logic [23:0] arg;
    logic [5:0] cnt;
    sfc_pkg::sfc_rmode_e rmode;
    logic [9:0] rpage;
    logic [8:0] rbyte;
    logic [2:0] rbit;
    logic rbuf;
    logic [8:0] wbyte;
    logic wbuf;
    logic [7:0] wsh;
    logic [2:0] wbit;
    logic pend_v;
    logic [17:0] pend;
    sfc_pkg::sfc_job_e job;
    sfc_pkg::sfc_op_e op;
    logic jbuf;
    logic [18:0] jbase;
    logic [11:0] jcnt;
    logic [11:0] jlen;
    logic [11:0] jtime;
    logic comp;
    logic so;
    logic so_oe_n;
  } sfc_eng_s;
  localparam sfc_eng_s ST_RST = '{ser: sfc_pkg::S_IDLE, rmode: sfc_pkg::M_STAT,
    job: sfc_pkg::J_IDLE, op: sfc_pkg::O_ERASE, cs_q: 1'b1, so_oe_n: 1'b1, default: '0};

  sfc_eng_s s, n;
  logic [2:0] pin_sy;
  logic cs, sck, si, rise, fall, cs_rise, cs_fall;
  logic [7:0] opc_nx, status, cur_byte, mem_rd, buf_rd, mem_jd, buf_jd, mem_wd, buf_wd;
  logic [23:0] arg_nx, arg_fin;
  logic [18:0] rd_addr, jidx, mem_wa;
  logic [9:0] buf_wa;
  logic mem_we, buf_we, wr_take;
  logic [7:0] mem [0:sfc_pkg::MEM_BYTES-1];
  logic [7:0] bufm [0:2*sfc_pkg::PAGE_BYTES-1];

  sfc_strm_if #(.W(18)) fin ();
  sfc_strm_if #(.W(18)) fout ();

  sfc_sync #(.W(3), .RST_VAL(sfc_pkg::PIN_RST)) u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .d({CS_N, SCK, SI}),
    .q(pin_sy)
  );

  sfc_fifo #(.WIDTH(18), .DEPTH(8)) u_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .in_s(fin.snk),
    .out_s(fout.src)
  );

  function automatic logic [9:0] buf_idx(input logic sel, input logic [8:0] a);
    buf_idx = sel ? ({1'b0, a} + sfc_pkg::BUF2_BASE) : {1'b0, a};
  endfunction : buf_idx

  function automatic logic is_arr(input logic [7:0] o);
    is_arr = (o == sfc_pkg::OP_PE1) || (o == sfc_pkg::OP_PE2) || (o == sfc_pkg::OP_PN1) ||
      (o == sfc_pkg::OP_PN2) || (o == sfc_pkg::OP_PGER) || (o == sfc_pkg::OP_BLER) ||
      (o == sfc_pkg::OP_XF1) || (o == sfc_pkg::OP_XF2) || (o == sfc_pkg::OP_CM1) ||
      (o == sfc_pkg::OP_CM2) || (o == sfc_pkg::OP_RW1) || (o == sfc_pkg::OP_RW2);
  endfunction : is_arr

  // Link edges seen through the synchroniser; the link clock is only sampled
  assign {cs, sck, si} = pin_sy;
  assign rise = sck & ~s.sck_q; // see RULE23
  assign fall = ~sck & s.sck_q; // see RULE23
  assign cs_rise = cs & ~s.cs_q;
  assign cs_fall = ~cs & s.cs_q;
  assign opc_nx = {s.opc[6:0], si}; // see RULE24
  assign arg_nx = {s.arg[22:0], si}; // see RULE24
  assign arg_fin = (s.cnt == sfc_pkg::ARG_LAST_ADDR) ? arg_nx : s.arg;

  // Live status byte, read afresh on every bit driven
  assign status = {s.job == sfc_pkg::J_IDLE, s.comp, sfc_pkg::DENSITY_CODE,
    sfc_pkg::STAT_RSVD}; // see RULE12 see RULE15 see RULE16

  // Array and buffer read ports for the link and for the job walker
  assign rd_addr = {9'h000, s.rpage} * sfc_pkg::PAGE_STRIDE + {10'h000, s.rbyte}; // see RULE6
  assign mem_rd = mem[rd_addr];
  assign buf_rd = bufm[buf_idx(s.rbuf, s.rbyte)];
  assign jidx = s.jbase + {7'h00, s.jcnt};
  assign mem_jd = mem[jidx];
  assign buf_jd = bufm[buf_idx(s.jbuf, s.jcnt[8:0])];
  assign wr_take = s.ser == sfc_pkg::S_WRITE && !cs && rise && s.wbit == 3'h7 &&
    (!s.pend_v || fin.ready);

  assign SO = s.so;
  assign SO_OE_N = s.so_oe_n;
  assign READY = status[sfc_pkg::STAT_RDY_BIT];

  // Burst and page reads feed from the array only
  always_comb begin
    case (s.rmode)
      sfc_pkg::M_MAIN: cur_byte = mem_rd;
      sfc_pkg::M_BURST: cur_byte = mem_rd; // see RULE4
      sfc_pkg::M_BUF: cur_byte = buf_rd;
      sfc_pkg::M_STAT: cur_byte = status;
      default: cur_byte = status;
    endcase
  end

  // Next-state logic for link decoder, write staging and job walker
  always_comb begin
    n = s;
    n.cs_q = cs;
    n.sck_q = sck;
    mem_we = 1'b0;
    mem_wa = jidx;
    mem_wd = 8'hff;
    fout.ready = (s.job != sfc_pkg::J_WALK);
    buf_we = fout.valid & fout.ready;
    buf_wa = buf_idx(fout.data[17], fout.data[16:8]);
    buf_wd = fout.data[7:0];
    fin.valid = s.pend_v;
    fin.data = s.pend;
    if (s.pend_v && fin.ready) begin
      n.pend_v = 1'b0;
    end
    if (cs) begin
      // Deselected: input ignored, output floats, array job launched after a complete array command while no job runs
      n.ser = sfc_pkg::S_IDLE; // see RULE26 see RULE3
      n.so_oe_n = 1'b1;
      n.so = 1'b0;
      if (cs_rise && s.ser == sfc_pkg::S_HOLD && s.job == sfc_pkg::J_IDLE) begin // see RULE25
        n.job = sfc_pkg::J_DRAIN; // see RULE14
        // Opcode bit zero does not track the buffer for every command, so decode each one
        n.jbuf = (s.opc == sfc_pkg::OP_PE2) || (s.opc == sfc_pkg::OP_PN2) ||
          (s.opc == sfc_pkg::OP_XF2) || (s.opc == sfc_pkg::OP_CM2) || (s.opc == sfc_pkg::OP_RW2);
        n.jbase = {9'h000, s.arg[sfc_pkg::PAGE_MSB:sfc_pkg::PAGE_LSB]} * sfc_pkg::PAGE_STRIDE;
        n.jlen = sfc_pkg::PAGE_LEN;
        case (s.opc)
          sfc_pkg::OP_PE1, sfc_pkg::OP_PE2: begin
            n.op = sfc_pkg::O_PROGE; // see RULE19
            n.jtime = sfc_pkg::EP_CYC;
          end
          sfc_pkg::OP_PN1, sfc_pkg::OP_PN2: begin
            n.op = sfc_pkg::O_PROG; // see RULE20
            n.jtime = sfc_pkg::P_CYC;
          end
          sfc_pkg::OP_BLER: begin
            n.op = sfc_pkg::O_BLOCK; // see RULE22
            n.jbase = {12'h000, s.arg[sfc_pkg::PAGE_MSB:sfc_pkg::BLOCK_LSB]} *
              sfc_pkg::BLOCK_STRIDE;
            n.jlen = sfc_pkg::BLOCK_LEN;
            n.jtime = sfc_pkg::BE_CYC;
          end
          sfc_pkg::OP_CM1, sfc_pkg::OP_CM2: begin
            n.op = sfc_pkg::O_CMP;
            n.jtime = sfc_pkg::XFR_CYC;
          end
          sfc_pkg::OP_XF1, sfc_pkg::OP_XF2, sfc_pkg::OP_RW1, sfc_pkg::OP_RW2: begin
            n.op = sfc_pkg::O_XFER;
            n.jtime = (s.opc[3]) ? sfc_pkg::EP_CYC : sfc_pkg::XFR_CYC;
          end
          default: begin
            n.op = sfc_pkg::O_ERASE; // see RULE21
            n.jtime = sfc_pkg::PE_CYC;
          end
        endcase
      end
    end else begin
      case (s.ser)
        sfc_pkg::S_IDLE: begin
          if (cs_fall) begin
            n.ser = sfc_pkg::S_OPC; // see RULE26
            n.cnt = '0;
          end
        end
        sfc_pkg::S_OPC: begin
          if (rise) begin
            n.opc = opc_nx;
            n.cnt = s.cnt + 6'h01;
            if (s.cnt == sfc_pkg::OPC_LAST) begin
              n.cnt = '0;
              n.rbit = 3'h7;
              if (opc_nx == sfc_pkg::OP_STAT_A || opc_nx == sfc_pkg::OP_STAT_B) begin
                n.ser = sfc_pkg::S_READ; // see RULE10
                n.rmode = sfc_pkg::M_STAT;
              end else if (opc_nx == sfc_pkg::OP_PGRD_A || opc_nx == sfc_pkg::OP_PGRD_B ||
                  opc_nx == sfc_pkg::OP_BURST_A || opc_nx == sfc_pkg::OP_BURST_B ||
                  opc_nx == sfc_pkg::OP_B1RD_A || opc_nx == sfc_pkg::OP_B1RD_B ||
                  opc_nx == sfc_pkg::OP_B2RD_A || opc_nx == sfc_pkg::OP_B2RD_B ||
                  opc_nx == sfc_pkg::OP_B1WR || opc_nx == sfc_pkg::OP_B2WR || is_arr(opc_nx)) begin
                n.ser = sfc_pkg::S_ARG;
              end else begin
                n.ser = sfc_pkg::S_SKIP; // see RULE27
              end
            end
          end
        end
        sfc_pkg::S_ARG: begin
          if (rise) begin
            n.cnt = s.cnt + 6'h01;
            if (s.cnt < sfc_pkg::ARG_BITS) begin
              n.arg = arg_nx;
            end
            n.rpage = arg_fin[sfc_pkg::PAGE_MSB:sfc_pkg::PAGE_LSB];
            n.rbyte = arg_fin[sfc_pkg::BYTE_MSB:0];
            if (s.opc == sfc_pkg::OP_B1WR || s.opc == sfc_pkg::OP_B2WR) begin
              if (s.cnt == sfc_pkg::ARG_LAST_ADDR) begin
                n.ser = sfc_pkg::S_WRITE; // see RULE17
                n.wbuf = (s.opc == sfc_pkg::OP_B2WR);
                n.wbyte = arg_fin[sfc_pkg::BYTE_MSB:0];
                n.wbit = '0;
              end
            end else if (is_arr(s.opc)) begin
              if (s.cnt == sfc_pkg::ARG_LAST_ADDR) begin
                n.ser = sfc_pkg::S_HOLD;
              end
            end else if (s.opc[2]) begin
              if (s.cnt == sfc_pkg::ARG_LAST_BUFRD) begin
                n.ser = sfc_pkg::S_READ; // see RULE8
                n.rmode = sfc_pkg::M_BUF;
                n.rbuf = s.opc[1];
              end
            end else if (s.cnt == sfc_pkg::ARG_LAST_MAIN) begin
              n.ser = sfc_pkg::S_READ; // see RULE5
              n.rmode = s.opc[3] ? sfc_pkg::M_BURST : sfc_pkg::M_MAIN;
            end
          end
        end
        sfc_pkg::S_READ: begin
          if (fall) begin
            n.so = cur_byte[s.rbit]; // see RULE23 see RULE24 see RULE11
            n.so_oe_n = 1'b0;
            n.rbit = s.rbit - 3'h1;
            if (s.rbit == 3'h0 && s.rmode != sfc_pkg::M_STAT) begin
              n.rbyte = (s.rbyte >= sfc_pkg::LAST_BYTE) ? '0 : s.rbyte + 9'h001; // see RULE7 see RULE9
              if (s.rmode == sfc_pkg::M_BURST && s.rbyte >= sfc_pkg::LAST_BYTE) begin
                n.rpage = s.rpage + 10'h001; // see RULE2
              end
            end
          end else if (s.rmode == sfc_pkg::M_STAT && s.rbit == 3'h6 && !s.so_oe_n) begin
            n.so = status[sfc_pkg::STAT_RDY_BIT]; // see RULE13
          end
        end
        sfc_pkg::S_WRITE: begin
          if (rise) begin
            n.wsh = {s.wsh[6:0], si};
            n.wbit = s.wbit + 3'h1;
          end
          // A byte that finds the staging slot still full is dropped
          if (wr_take) begin
            n.pend_v = 1'b1;
            n.pend = {s.wbuf, s.wbyte, s.wsh[6:0], si};
            n.wbyte = (s.wbyte >= sfc_pkg::LAST_BYTE) ? '0 : s.wbyte + 9'h001; // see RULE18
          end
        end
        sfc_pkg::S_HOLD, sfc_pkg::S_SKIP: begin
          n.ser = s.ser;
        end
        default: n.ser = sfc_pkg::S_SKIP;
      endcase
    end
    // Job walker: drain pending writes, touch each byte, then self-time
    case (s.job)
      sfc_pkg::J_IDLE: n.jcnt = '0;
      sfc_pkg::J_DRAIN: begin
        if (!s.pend_v && !fout.valid) begin
          n.job = sfc_pkg::J_WALK;
          n.comp = (s.op == sfc_pkg::O_CMP) ? 1'b0 : s.comp;
        end
      end
      sfc_pkg::J_WALK: begin
        n.jcnt = s.jcnt + 12'h001;
        mem_we = (s.op != sfc_pkg::O_XFER) && (s.op != sfc_pkg::O_CMP);
        if (s.op == sfc_pkg::O_PROGE) begin
          mem_wd = buf_jd;
        end else if (s.op == sfc_pkg::O_PROG) begin
          mem_wd = mem_jd & buf_jd; // Programming only clears bits
        end
        if (s.op == sfc_pkg::O_XFER) begin
          buf_we = 1'b1;
          buf_wa = buf_idx(s.jbuf, s.jcnt[8:0]);
          buf_wd = mem_jd;
        end
        if (s.op == sfc_pkg::O_CMP && mem_jd != buf_jd) begin
          n.comp = 1'b1; // see RULE15
        end
        if (s.jcnt == s.jlen - 12'h001) begin
          n.job = sfc_pkg::J_TIME;
        end
      end
      sfc_pkg::J_TIME: begin
        n.jtime = s.jtime - 12'h001;
        if (s.jtime == '0) begin
          n.job = sfc_pkg::J_IDLE; // see RULE12
        end
      end
      default: n.job = sfc_pkg::J_IDLE;
    endcase
  end

  // Array and buffer storage, no reset
  always_ff @(posedge REF_CLK) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (buf_we) begin
      bufm[buf_wa] <= buf_wd;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_job_go;
    cs_rise && s.ser == sfc_pkg::S_HOLD && s.job == sfc_pkg::J_IDLE;
  endsequence
  sequence s_byte_end;
    s.ser == sfc_pkg::S_READ && !cs && fall && s.rbit == 3'h0 &&
      s.rbyte == sfc_pkg::LAST_BYTE;
  endsequence

  property p_float;
    cs |=> SO_OE_N ##1 SO_OE_N;
  endproperty
  a_float: assert property (p_float) else $error("output driven while deselected"); // see RULE26
  property p_rd_end;
    (s.ser == sfc_pkg::S_READ) ##1 cs_rise |=> s.ser == sfc_pkg::S_IDLE && SO_OE_N;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("read not ended by select"); // see RULE3
  property p_busy;
    s_job_go |=> s.job == sfc_pkg::J_DRAIN ##1 !READY;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not raised for job"); // see RULE14
  property p_ready;
    s.job == sfc_pkg::J_TIME && s.jtime == '0 |=> READY && status[7];
  endproperty
  a_ready: assert property (p_ready) else $error("ready not raised at end"); // see RULE12
  property p_page_wrap;
    s_byte_end and s.rmode == sfc_pkg::M_MAIN |=> s.rbyte == '0 && s.rpage == $past(s.rpage);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page read left page"); // see RULE7
  property p_burst_wrap;
    s_byte_end and s.rmode == sfc_pkg::M_BURST && s.rpage == sfc_pkg::LAST_PAGE
      |=> s.rbyte == '0 && s.rpage == '0;
  endproperty
  a_burst_wrap: assert property (p_burst_wrap) else $error("burst did not wrap"); // see RULE2
  property p_buf_wrap;
    s_byte_end and s.rmode == sfc_pkg::M_BUF |=> s.rbyte == '0;
  endproperty
  a_buf_wrap: assert property (p_buf_wrap) else $error("buffer read did not wrap"); // see RULE9
  property p_wr_wrap;
    wr_take && s.wbyte == sfc_pkg::LAST_BYTE |=> s.wbyte == '0 && s.pend_v;
  endproperty
  a_wr_wrap: assert property (p_wr_wrap) else $error("buffer write did not wrap"); // see RULE18
  property p_erase_ones;
    mem_we && (s.op == sfc_pkg::O_ERASE || s.op == sfc_pkg::O_BLOCK) |-> mem_wd == 8'hff;
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("erase wrote zero bits"); // see RULE21
  property p_skip;
    s.ser == sfc_pkg::S_SKIP && !cs |=> s.ser == sfc_pkg::S_SKIP && SO_OE_N;
  endproperty
  a_skip: assert property (p_skip) else $error("unknown opcode acted on"); // see RULE27
  property p_stat_msb;
    s.ser == sfc_pkg::S_READ && s.rmode == sfc_pkg::M_STAT && !cs && fall && s.rbit == 3'h7
      |=> SO == $past(READY) && s.rbit == 3'h6;
  endproperty
  a_stat_msb: assert property (p_stat_msb) else $error("status bit seven wrong"); // see RULE10
endmodule : sfc_engine

// ===== rtl/sfc_fifo.sv
// Parameterised valid/ready FIFO for buffer write data
`timescale 1ns/1ps
module sfc_fifo #(parameter int WIDTH = 18, parameter int DEPTH = 8) (
  input logic clk,
  input logic rst,
  sfc_strm_if.snk in_s,
  sfc_strm_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sfc_fifo_s;
  sfc_fifo_s s, n;
  logic [WIDTH-1:0] ram [0:DEPTH-1];
  logic push, pop;

  // Honest flags straight from the occupancy count
  assign in_s.ready = (s.cnt != (AW + 1)'(DEPTH));
  assign out_s.valid = (s.cnt != '0);
  assign out_s.data = ram[s.rp];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  // Pointers wrap by overflow, so DEPTH must be a power of two
  always_comb begin
    n = s;
    if (push) begin
      n.wp = s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = s.rp + 1'b1;
    end
    n.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (push) begin
      ram[s.wp] <= in_s.data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : sfc_fifo

// ===== rtl/sfc_pkg.sv
// Constants, enumerations and timing counts for the serial flash command engine
package sfc_pkg;
  // Array geometry
  localparam int PAGE_BYTES = 264;
  localparam int PAGES = 1024;
  localparam int MEM_BYTES = PAGES * PAGE_BYTES;
  localparam logic [8:0] LAST_BYTE = 9'h107;
  localparam logic [9:0] LAST_PAGE = 10'h3ff;
  localparam logic [18:0] PAGE_STRIDE = 19'h108;
  localparam logic [18:0] BLOCK_STRIDE = 19'h840;
  localparam logic [11:0] PAGE_LEN = 12'h108;
  localparam logic [11:0] BLOCK_LEN = 12'h840;
  localparam logic [9:0] BUF2_BASE = 10'h108;
  // Serial framing: last bit index of opcode and of each argument form, and the address bit count
  localparam logic [5:0] OPC_LAST = 6'h07;
  localparam logic [5:0] ARG_LAST_ADDR = 6'h17;
  localparam logic [5:0] ARG_LAST_BUFRD = 6'h1f;
  localparam logic [5:0] ARG_LAST_MAIN = 6'h37;
  localparam logic [5:0] ARG_BITS = 6'h18;
  // Address fields inside the 24-bit argument
  localparam int PAGE_MSB = 18;
  localparam int PAGE_LSB = 9;
  localparam int BLOCK_LSB = 12;
  localparam int BYTE_MSB = 8;
  // Opcodes
  localparam logic [7:0] OP_PGRD_A = 8'h52;
  localparam logic [7:0] OP_PGRD_B = 8'hd2;
  localparam logic [7:0] OP_BURST_A = 8'h68;
  localparam logic [7:0] OP_BURST_B = 8'he8;
  localparam logic [7:0] OP_B1RD_A = 8'h54;
  localparam logic [7:0] OP_B1RD_B = 8'hd4;
  localparam logic [7:0] OP_B2RD_A = 8'h56;
  localparam logic [7:0] OP_B2RD_B = 8'hd6;
  localparam logic [7:0] OP_STAT_A = 8'h57;
  localparam logic [7:0] OP_STAT_B = 8'hd7;
  localparam logic [7:0] OP_B1WR = 8'h84;
  localparam logic [7:0] OP_B2WR = 8'h87;
  localparam logic [7:0] OP_PE1 = 8'h83;
  localparam logic [7:0] OP_PE2 = 8'h86;
  localparam logic [7:0] OP_PN1 = 8'h88;
  localparam logic [7:0] OP_PN2 = 8'h89;
  localparam logic [7:0] OP_PGER = 8'h81;
  localparam logic [7:0] OP_BLER = 8'h50;
  localparam logic [7:0] OP_XF1 = 8'h53;
  localparam logic [7:0] OP_XF2 = 8'h55;
  localparam logic [7:0] OP_CM1 = 8'h60;
  localparam logic [7:0] OP_CM2 = 8'h61;
  localparam logic [7:0] OP_RW1 = 8'h58;
  localparam logic [7:0] OP_RW2 = 8'h59;
  // Status byte layout and pin reset value; density code value is arbitrary
  localparam int STAT_RDY_BIT = 7;
  localparam logic [2:0] DENSITY_CODE = 3'h5;
  localparam logic [2:0] STAT_RSVD = 3'h0;
  localparam logic [2:0] PIN_RST = 3'h4;
  // Self-timed operation times in microseconds and the derived cycle counts
  localparam int CLK_MHZ = 100;
  localparam int EP_TIME_US = 20;
  localparam int P_TIME_US = 15;
  localparam int PE_TIME_US = 8;
  localparam int BE_TIME_US = 30;
  localparam int XFR_TIME_US = 2;
  localparam logic [11:0] EP_CYC = 12'(EP_TIME_US * CLK_MHZ);
  localparam logic [11:0] P_CYC = 12'(P_TIME_US * CLK_MHZ);
  localparam logic [11:0] PE_CYC = 12'(PE_TIME_US * CLK_MHZ);
  localparam logic [11:0] BE_CYC = 12'(BE_TIME_US * CLK_MHZ);
  localparam logic [11:0] XFR_CYC = 12'(XFR_TIME_US * CLK_MHZ);
  // State and mode encodings
  typedef enum logic [6:0] {S_IDLE = 7'h01, S_OPC = 7'h02, S_ARG = 7'h04, S_READ = 7'h08,
    S_WRITE = 7'h10, S_HOLD = 7'h20, S_SKIP = 7'h40} sfc_ser_e;
  typedef enum logic [3:0] {M_MAIN = 4'h1, M_BURST = 4'h2, M_BUF = 4'h4,
    M_STAT = 4'h8} sfc_rmode_e;
  typedef enum logic [3:0] {J_IDLE = 4'h1, J_DRAIN = 4'h2, J_WALK = 4'h4,
    J_TIME = 4'h8} sfc_job_e;
  typedef enum logic [5:0] {O_ERASE = 6'h01, O_BLOCK = 6'h02, O_PROGE = 6'h04,
    O_PROG = 6'h08, O_XFER = 6'h10, O_CMP = 6'h20} sfc_op_e;
endpackage : sfc_pkg

// ===== rtl/sfc_strm_if.sv
// Valid/ready stream carrier between the engine and its write FIFO
`timescale 1ns/1ps
interface sfc_strm_if #(parameter int W = 18) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sfc_strm_if

// ===== rtl/sfc_sync.sv
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module sfc_sync #(parameter int W = 3, parameter logic [W-1:0] RST_VAL = '0) (
  input logic clk,
  input logic rst,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfc_sync_s;
  sfc_sync_s s, n;

  // First stage feeds only the second stage
  always_comb begin
    n.s1 = d;
    n.s2 = s.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= {RST_VAL, RST_VAL};
    end else begin
      s <= n;
    end
  end

  assign q = s.s2;
endmodule : sfc_sync

// ===== testbench/sfc_host.sv
// Host model that frames commands and shifts bytes over the serial link
`timescale 1ns/1ps
module sfc_host (
  output logic CS_N,
  output logic SCK,
  output logic SI,
  input wire logic SO,
  input wire logic SO_OE_N
);
  logic so_last;
  logic so_line;
  initial begin
    CS_N = 1'b1;
    SCK = 1'b0;
    SI = 1'b0;
    so_last = 1'b0;
  end
  // A released line shows the inverse of its last driven value, never a stale match
  always @(SO or SO_OE_N) begin
    if (!SO_OE_N) so_last = SO;
  end
  assign so_line = SO_OE_N ? ~so_last : SO;
  // Select low for the whole frame, link clock stands still outside it
  task sel();
    #100 CS_N = 1'b0;
    #100;
  endtask : sel
  task desel();
    #100 CS_N = 1'b1;
    #300;
  endtask : desel
  // Drive on the fall, sample on the rise, most significant bit first
  task shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      SI = tx[i];
      #62.5 SCK = 1'b1;
      rx[i] = so_line;
      #62.5 SCK = 1'b0;
    end
  endtask : shift
endmodule : sfc_host

// ===== testbench/testbench.sv
// Self-checking bench for the serial flash command engine
`timescale 1ns/1ps
module testbench;
  logic REF_CLK, RST, CS_N, SCK, SI, SO, SO_OE_N, READY;
  logic [7:0] r0, r1, r2, d;
  logic [7:0] stat;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  sfc_engine DUT (.REF_CLK(REF_CLK), .RST(RST), .CS_N(CS_N), .SCK(SCK), .SI(SI), .SO(SO),
    .SO_OE_N(SO_OE_N), .READY(READY));
  sfc_host u_host (.CS_N(CS_N), .SCK(SCK), .SI(SI), .SO(SO), .SO_OE_N(SO_OE_N));
  // System clock
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task stop_test();
    $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  // Opcode plus the 24-bit argument, frame left open
  task cmd(input logic [7:0] op, input logic [23:0] arg);
    u_host.sel();
    u_host.shift(op, d);
    for (int i = 2; i >= 0; i--) u_host.shift(arg[i*8 +: 8], d);
  endtask : cmd
  // Read command: dummy bytes, then three data bytes, then close
  task rd(input logic [7:0] op, input logic [23:0] arg, input int dummies);
    cmd(op, arg);
    repeat (dummies) u_host.shift(8'h00, d);
    u_host.shift(8'h00, r0);
    u_host.shift(8'h00, r1);
    u_host.shift(8'h00, r2);
    u_host.desel();
  endtask : rd
  // Burst read of two bytes across a page boundary, clock held off at the boundary
  task brd(input logic [23:0] arg);
    cmd(sfc_pkg::OP_BURST_A, arg);
    repeat (4) u_host.shift(8'h00, d);
    u_host.shift(8'h00, r0);
    #500;
    u_host.shift(8'h00, r1);
    u_host.desel();
  endtask : brd
  // Bounded wait for the array job to end; host starts no array job while busy
  task wait_ready();
    for (int n = 0; n < 6000 && READY !== 1'b1; n++) @(negedge REF_CLK);
    check("READY", {7'h00, READY}, 8'h01);
  endtask : wait_ready
  // Hang guard
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      stop_test();
    end
  end
  // Main sequence
  initial begin
    RST = 1'b1;
    stat = {2'b10, sfc_pkg::DENSITY_CODE, sfc_pkg::STAT_RSVD};
    repeat (6) @(posedge REF_CLK);
    @(negedge REF_CLK) RST = 1'b0;
    #100;
    u_host.sel();
    u_host.shift(8'h00, d);
    check("SO_OE_N unknown op", {7'h00, SO_OE_N}, 8'h01);
    u_host.desel();
    u_host.sel();
    u_host.shift(sfc_pkg::OP_STAT_A, d);
    u_host.shift(8'h00, r0);
    u_host.shift(8'h00, r1);
    u_host.desel();
    check("status", r0 & 8'hbf, stat);
    check("status repeat", r1 & 8'hbf, stat);
    check("SO_OE_N idle", {7'h00, SO_OE_N}, 8'h01);
    $display("test status done");
    cmd(sfc_pkg::OP_B1WR, 24'h000106);
    u_host.shift(8'ha5, d);
    u_host.shift(8'h3c, d);
    u_host.shift(8'h69, d);
    u_host.desel();
    rd(sfc_pkg::OP_B1RD_A, 24'h000106, 1);
    check("buf 106", r0, 8'ha5);
    check("buf 000", r2, 8'h69);
    $display("test buffer done");
    wait_ready();
    cmd(sfc_pkg::OP_PGER, {5'h00, 10'h005, 9'h000});
    u_host.desel();
    check("busy erase", {7'h00, READY}, 8'h00);
    wait_ready();
    rd(sfc_pkg::OP_PGRD_A, {5'h00, 10'h005, 9'h106}, 4);
    check("erased", r0 & r1 & r2, 8'hff);
    $display("test erase done");
    cmd(sfc_pkg::OP_PE1, {5'h00, 10'h005, 9'h000});
    u_host.desel();
    u_host.sel();
    u_host.shift(8'h00, d);
    u_host.desel();
    u_host.sel();
    u_host.shift(sfc_pkg::OP_STAT_B, d);
    #200 check("SO busy", {7'h00, SO}, 8'h00);
    wait_ready();
    repeat (3) @(negedge REF_CLK);
    check("SO ready", {7'h00, SO}, 8'h01);
    u_host.desel();
    rd(sfc_pkg::OP_PGRD_B, {5'h00, 10'h005, 9'h106}, 4);
    check("page 106", r0, 8'ha5);
    check("page 107", r1, 8'h3c);
    check("page 000", r2, 8'h69);
    $display("test program done");
    brd({5'h00, 10'h004, 9'h107});
    check("burst next page", r1, 8'h69);
    cmd(sfc_pkg::OP_BLER, {5'h00, 7'h00, 12'h000});
    u_host.desel();
    check("busy block", {7'h00, READY}, 8'h00);
    wait_ready();
    brd({5'h00, sfc_pkg::LAST_PAGE, sfc_pkg::LAST_BYTE});
    check("burst wrap", r1, 8'hff);
    rd(sfc_pkg::OP_B1RD_B, 24'h000106, 1);
    check("buf kept", r0, 8'ha5);
    $display("test burst done");
    stop_test();
  end
endmodule : testbench
